// ==== pwct_pkg.sv ====
// constants and types shared by the pulse width capture timer
package pwct_pkg;
	// ==========================================================
	// bus and widths
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W   = 4;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned IRQ_W  = 4;
	localparam int unsigned PRE_W  = 8;
	localparam int unsigned NTAP   = 3;
	localparam int unsigned TAP_LOG [NTAP] = '{1, 3, 5};
	// ==========================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_RUN    = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_FFCTL  = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_MODE   = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_CMP0   = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_CMP1   = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_CAP0   = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_CAP1   = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 6'h28;
	// ==========================================================
	// field positions
	localparam int unsigned EN_BIT       = 7;
	localparam int unsigned RUN_CNT_BIT  = 0;
	localparam int unsigned RUN_PRE_BIT  = 2;
	localparam int unsigned MODE_CLK_LSB = 0;
	localparam int unsigned MODE_CLE_BIT = 2;
	localparam int unsigned MODE_CPM_LSB = 4;
	localparam int unsigned MODE_SWC_BIT = 6;
	localparam int unsigned FF_CTL_LSB   = 0;
	localparam int unsigned FF_INV_LSB   = 2;
	localparam int unsigned ST_CAP0      = 0;
	localparam int unsigned ST_CAP1      = 1;
	localparam int unsigned ST_CMP0      = 2;
	localparam int unsigned ST_CMP1      = 3;
	// ==========================================================
	// reset and read-back values
	localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
	localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_ZERO  = 4'h0;
	localparam logic [3:0] FF_INV_RST      = 4'h0;
	localparam logic [1:0] FF_CTL_READ     = 2'h3;
	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		CLK_PIN  = 2'b00,
		CLK_TAP1 = 2'b01,
		CLK_TAP2 = 2'b10,
		CLK_TAP3 = 2'b11
	} pwct_clk_t;
	typedef enum logic [1:0] {
		CPM_OFF  = 2'b00,
		CPM_RSV1 = 2'b01,
		CPM_EDGE = 2'b10,
		CPM_RSV3 = 2'b11
	} pwct_cpm_t;
	typedef enum logic [1:0] {
		FFC_INV = 2'b00,
		FFC_SET = 2'b01,
		FFC_CLR = 2'b10,
		FFC_NOP = 2'b11
	} pwct_ffc_t;
endpackage

// ==== pwct_prescaler.sv ====
// prescaler: divider that counts while run is high, giving one-cycle ticks on each tap
`timescale 1ns/100ps
module pwct_prescaler
	import pwct_pkg::*;
#(
	parameter int unsigned W = PRE_W
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            ce,
	input  wire logic            run,
	output logic      [NTAP-1:0] tick
);
	// ==========================================================
	// divider
	logic [W-1:0]    cnt_r;
	logic [W-1:0]    cnt_nxt;
	logic [NTAP-1:0] tick_r;
	logic [NTAP-1:0] tick_nxt;

	always_comb begin
		cnt_nxt = run ? W'(cnt_r + 1'b1) : cnt_r;
	end

	for (genvar i = 0; i < NTAP; i++) begin : g_tap
		assign tick_nxt[i] = run && (&cnt_r[TAP_LOG[i]-1:0]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			tick_r <= '0;
		end else if (ce) begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

// ==== pwct_top.sv ====
// pulse width capture timer channel with avalon-mm register slave
// Contract
// R01: mode 10: rise to cap0, fall to cap1
// R02: falling edge stores cap1, raises capture1 irq
// R03: counter steps once per prescaler tick
// R04: software corrects widths beyond counter range
// R05: every rising capture raises capture0 irq
// R06: run bits stop or start prescaler, counter
// R07: flip-flop inversion disable and preset zero
// R08: mode selects free-run, tap, edge capture
// R09: software stops counter before reconfiguring
// R10: 16-bit wrapping counter, captures hold
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module pwct_top
	import pwct_pkg::*;
#(
	parameter int unsigned CW = CNT_W
) (
	input  wire logic              REF_CLK,
	input  wire logic              RESET_N,
	input  wire logic              CE,
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [DATA_W-1:0] AVS_WRITEDATA,
	input  wire logic [BE_W-1:0]   AVS_BYTEENABLE,
	output logic      [DATA_W-1:0] AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	input  wire logic              CAPTURE_INPUT_PIN,
	output logic                   TIMER_FLIPFLOP_OUT,
	output logic                   CAPTURE0_IRQ,
	output logic                   CAPTURE1_IRQ,
	output logic                   IRQ
);
	// ==========================================================
	// state
	logic              ack_r,      ack_nxt;
	logic [DATA_W-1:0] rdata_r,    rdata_nxt;
	logic              en_r,       en_nxt;
	logic              run_pre_r,  run_pre_nxt;
	logic              run_cnt_r,  run_cnt_nxt;
	pwct_clk_t         clk_sel_r,  clk_sel_nxt;
	logic              cle_r,      cle_nxt;
	pwct_cpm_t         cpm_r,      cpm_nxt;
	logic [3:0]        ff_inv_r,   ff_inv_nxt;
	logic              ff_r,       ff_nxt;
	logic [CW-1:0]     cmp0_r,     cmp0_nxt;
	logic [CW-1:0]     cmp1_r,     cmp1_nxt;
	logic [CW-1:0]     cap0_r,     cap0_nxt;
	logic [CW-1:0]     cap1_r,     cap1_nxt;
	logic [CW-1:0]     count_r,    count_nxt;
	logic [IRQ_W-1:0]  status_r,   status_nxt;
	logic [IRQ_W-1:0]  mask_r,     mask_nxt;
	logic              pin_prev_r, pin_prev_nxt;
	logic              c0p_r,      c0p_nxt;
	logic              c1p_r,      c1p_nxt;

	// ==========================================================
	// bus decode
	logic              req;
	logic              wr_fire;
	logic              rd_fire;
	logic [DATA_W-1:0] wmask;
	logic [DATA_W-1:0] wval;
	logic [DATA_W-1:0] rd_mux;

	assign req     = AVS_READ || AVS_WRITE;
	assign wr_fire = AVS_WRITE && ack_r;
	assign rd_fire = AVS_READ && ack_r;

	for (genvar b = 0; b < BE_W; b++) begin : g_be
		assign wmask[8*b +: 8] = {8{AVS_BYTEENABLE[b]}};
	end

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old);
		merge = (old & ~wmask) | (AVS_WRITEDATA & wmask);
	endfunction

	// ==========================================================
	// prescaler and events
	logic [NTAP-1:0] tap;
	logic            sel_tick;
	logic            step;
	logic            wrap_clr;
	logic            pin_rise;
	logic            pin_fall;
	logic            swcap;
	logic            cap0_ev;
	logic            cap1_ev;
	logic            m0_ev;
	logic            m1_ev;
	logic            ff_wr;
	logic [1:0]      ff_cmd;
	logic [IRQ_W-1:0] ev;

	pwct_prescaler #(
		.W (PRE_W)
	) u_pre (
		.clk   (REF_CLK),
		.rst_n (RESET_N),
		.ce    (CE),
		.run   (en_r && run_pre_r), // [R06]
		.tick  (tap)
	);

	assign pin_rise = CAPTURE_INPUT_PIN && !pin_prev_r;
	assign pin_fall = !CAPTURE_INPUT_PIN && pin_prev_r;

	always_comb begin
		unique case (clk_sel_r) // [R08]
			CLK_PIN:  sel_tick = pin_rise;
			CLK_TAP1: sel_tick = tap[0];
			CLK_TAP2: sel_tick = tap[1];
			CLK_TAP3: sel_tick = tap[2];
		endcase
	end

	assign step     = en_r && run_cnt_r && sel_tick; // [R03] [R06]
	assign wrap_clr = cle_r && (count_r == cmp1_r);
	assign m0_ev    = step && (count_r == cmp0_r);
	assign m1_ev    = step && (count_r == cmp1_r);
	assign swcap    = wr_fire && (AVS_ADDRESS == OFS_MODE) && AVS_BYTEENABLE[0]
		&& !AVS_WRITEDATA[MODE_SWC_BIT];
	assign cap0_ev  = en_r && ((cpm_r == CPM_EDGE && pin_rise) || swcap); // [R01] [R05]
	assign cap1_ev  = en_r && cpm_r == CPM_EDGE && pin_fall; // [R01] [R02]
	assign ff_wr    = wr_fire && (AVS_ADDRESS == OFS_FFCTL) && AVS_BYTEENABLE[0];
	assign ff_cmd   = AVS_WRITEDATA[FF_CTL_LSB +: 2];

	always_comb begin
		ev          = '0;
		ev[ST_CAP0] = cap0_ev;
		ev[ST_CAP1] = cap1_ev;
		ev[ST_CMP0] = m0_ev;
		ev[ST_CMP1] = m1_ev;
	end

	// ==========================================================
	// read mux
	always_comb begin
		rd_mux = RD_ZERO;
		case (AVS_ADDRESS)
			OFS_ENABLE: rd_mux[EN_BIT] = en_r;
			OFS_RUN: begin
				rd_mux[RUN_CNT_BIT] = run_cnt_r;
				rd_mux[RUN_PRE_BIT] = run_pre_r;
			end
			OFS_FFCTL: begin
				rd_mux[FF_CTL_LSB +: 2] = FF_CTL_READ;
				rd_mux[FF_INV_LSB +: 4] = ff_inv_r;
			end
			OFS_MODE: begin
				rd_mux[MODE_CLK_LSB +: 2] = clk_sel_r;
				rd_mux[MODE_CLE_BIT]      = cle_r;
				rd_mux[MODE_CPM_LSB +: 2] = cpm_r;
				rd_mux[MODE_SWC_BIT]      = 1'b1;
			end
			OFS_CMP0:   rd_mux[CW-1:0]    = cmp0_r;
			OFS_CMP1:   rd_mux[CW-1:0]    = cmp1_r;
			OFS_CAP0:   rd_mux[CW-1:0]    = cap0_r;
			OFS_CAP1:   rd_mux[CW-1:0]    = cap1_r;
			OFS_COUNT:  rd_mux[CW-1:0]    = count_r;
			OFS_STATUS: rd_mux[IRQ_W-1:0] = status_r;
			OFS_MASK:   rd_mux[IRQ_W-1:0] = mask_r;
			default:    rd_mux = RD_ZERO;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		ack_nxt      = req && !ack_r;
		rdata_nxt    = (AVS_READ && !ack_r) ? rd_mux : rdata_r;
		wval         = merge(RD_ZERO);
		en_nxt       = en_r;
		run_pre_nxt  = run_pre_r;
		run_cnt_nxt  = run_cnt_r;
		clk_sel_nxt  = clk_sel_r;
		cle_nxt      = cle_r;
		cpm_nxt      = cpm_r;
		ff_inv_nxt   = ff_inv_r;
		cmp0_nxt     = cmp0_r;
		cmp1_nxt     = cmp1_r;
		mask_nxt     = mask_r;
		pin_prev_nxt = CAPTURE_INPUT_PIN;
		c0p_nxt      = cap0_ev;
		c1p_nxt      = cap1_ev;
		if (wr_fire) begin
			case (AVS_ADDRESS)
				OFS_ENABLE: begin
					wval   = merge({24'h000000, en_r, 7'h00});
					en_nxt = wval[EN_BIT];
				end
				OFS_RUN: begin
					wval        = merge({29'h00000000, run_pre_r, 1'b0, run_cnt_r});
					run_cnt_nxt = wval[RUN_CNT_BIT]; // [R06]
					run_pre_nxt = wval[RUN_PRE_BIT]; // [R06]
				end
				OFS_FFCTL: begin
					wval       = merge({26'h0000000, ff_inv_r, FF_CTL_READ});
					ff_inv_nxt = wval[FF_INV_LSB +: 4]; // [R07]
				end
				OFS_MODE: begin
					wval        = merge({25'h0000000, 1'b1, cpm_r, 1'b0, cle_r, clk_sel_r});
					clk_sel_nxt = pwct_clk_t'(wval[MODE_CLK_LSB +: 2]); // [R08]
					cle_nxt     = wval[MODE_CLE_BIT]; // [R08]
					cpm_nxt     = pwct_cpm_t'(wval[MODE_CPM_LSB +: 2]); // [R08]
				end
				OFS_CMP0: begin
					wval     = merge({16'h0000, cmp0_r});
					cmp0_nxt = wval[CW-1:0];
				end
				OFS_CMP1: begin
					wval     = merge({16'h0000, cmp1_r});
					cmp1_nxt = wval[CW-1:0];
				end
				OFS_MASK: begin
					wval     = merge({28'h0000000, mask_r});
					mask_nxt = wval[IRQ_W-1:0];
				end
				default: wval = merge(RD_ZERO);
			endcase
		end
	end

	// counter, captures, flip-flop, status
	always_comb begin
		count_nxt = count_r;
		if (step) begin
			count_nxt = wrap_clr ? CNT_ZERO : CW'(count_r + CNT_ONE); // [R03] [R10]
		end
		cap0_nxt = cap0_ev ? count_r : cap0_r; // [R01] [R10]
		cap1_nxt = cap1_ev ? count_r : cap1_r; // [R02] [R10]
		ff_nxt   = ff_r ^ ((m0_ev && ff_inv_r[2]) ^ (m1_ev && ff_inv_r[3])
			^ (cap0_ev && ff_inv_r[0]) ^ (cap1_ev && ff_inv_r[1])); // [R07]
		if (ff_wr) begin
			unique case (pwct_ffc_t'(ff_cmd))
				FFC_INV: ff_nxt = !ff_r;
				FFC_SET: ff_nxt = 1'b1;
				FFC_CLR: ff_nxt = 1'b0; // [R07]
				FFC_NOP: ff_nxt = ff_r;
			endcase
		end
		status_nxt = status_r;
		if (rd_fire && AVS_ADDRESS == OFS_STATUS) begin
			status_nxt = status_r & ~rdata_r[IRQ_W-1:0];
		end
		status_nxt = status_nxt | ev; // [R02] [R05]
	end

	// ==========================================================
	// registers
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ack_r      <= 1'b0;
			rdata_r    <= RD_ZERO;
			en_r       <= 1'b0;
			run_pre_r  <= 1'b0;
			run_cnt_r  <= 1'b0;
			clk_sel_r  <= CLK_PIN;
			cle_r      <= 1'b0;
			cpm_r      <= CPM_OFF;
			ff_inv_r   <= FF_INV_RST;
			ff_r       <= 1'b0;
			cmp0_r     <= CNT_ZERO;
			cmp1_r     <= CNT_ZERO;
			cap0_r     <= CNT_ZERO;
			cap1_r     <= CNT_ZERO;
			count_r    <= CNT_ZERO;
			status_r   <= IRQ_ZERO;
			mask_r     <= IRQ_ZERO;
			pin_prev_r <= 1'b0;
			c0p_r      <= 1'b0;
			c1p_r      <= 1'b0;
		end else if (CE) begin
			ack_r      <= ack_nxt;
			rdata_r    <= rdata_nxt;
			en_r       <= en_nxt;
			run_pre_r  <= run_pre_nxt;
			run_cnt_r  <= run_cnt_nxt;
			clk_sel_r  <= clk_sel_nxt;
			cle_r      <= cle_nxt;
			cpm_r      <= cpm_nxt;
			ff_inv_r   <= ff_inv_nxt;
			ff_r       <= ff_nxt;
			cmp0_r     <= cmp0_nxt;
			cmp1_r     <= cmp1_nxt;
			cap0_r     <= cap0_nxt;
			cap1_r     <= cap1_nxt;
			count_r    <= count_nxt;
			status_r   <= status_nxt;
			mask_r     <= mask_nxt;
			pin_prev_r <= pin_prev_nxt;
			c0p_r      <= c0p_nxt;
			c1p_r      <= c1p_nxt;
		end
	end

	assign AVS_READDATA       = rdata_r;
	assign AVS_WAITREQUEST    = req && !ack_r;
	assign TIMER_FLIPFLOP_OUT = ff_r;
	assign CAPTURE0_IRQ       = c0p_r;
	assign CAPTURE1_IRQ       = c1p_r;
	assign IRQ                = |(status_r & mask_r);

	// ==========================================================
	// assertions
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	property p_rise_cap0;
		(CE && en_r && cpm_r == CPM_EDGE && pin_rise) |=> (cap0_r == $past(count_r)) && c0p_r;
	endproperty
	a_rise_cap0: assert property (p_rise_cap0) else $error("rise not captured"); // [R01]

	property p_fall_cap1;
		(CE && en_r && cpm_r == CPM_EDGE && pin_fall) |=> (cap1_r == $past(count_r))
			&& status_r[ST_CAP1] && c1p_r ##1 !c1p_r || !CE;
	endproperty
	a_fall_cap1: assert property (p_fall_cap1) else $error("fall capture wrong"); // [R02]

	property p_step;
		(CE && step && !wrap_clr) |=> count_r == CW'($past(count_r) + CNT_ONE);
	endproperty
	a_step: assert property (p_step) else $error("counter step wrong"); // [R03]

	property p_cap0_irq;
		(CE && cap0_ev) |=> status_r[ST_CAP0];
	endproperty
	a_cap0_irq: assert property (p_cap0_irq) else $error("capture0 flag missing"); // [R05]

	property p_stop;
		(CE && !run_cnt_r) |=> $stable(count_r);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped counter moved"); // [R06]

	property p_ff_clr;
		(CE && ff_wr && ff_cmd == FFC_CLR) |=> !TIMER_FLIPFLOP_OUT;
	endproperty
	a_ff_clr: assert property (p_ff_clr) else $error("flip-flop preset failed"); // [R07]

	property p_no_capture;
		(CE && cpm_r != CPM_EDGE) |=> $stable(cap1_r);
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("capture in wrong mode"); // [R08]

	property p_wrap;
		(CE && step && !cle_r && count_r == {CW{1'b1}}) |=> count_r == CNT_ZERO;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // [R10]

	property p_hold;
		(!cap0_ev || !CE) |=> $stable(cap0_r);
	endproperty
	a_hold: assert property (p_hold) else $error("capture0 changed"); // [R10]

	c_cap1:  cover property (CE && cap1_ev);
	c_irq:   cover property ($rose(IRQ));
	c_wrap:  cover property (CE && step && count_r == {CW{1'b1}});
	c_swcap: cover property (CE && swcap);
endmodule

// ==== pwct_pulse_src.sv ====
// external pulse source model driving the capture input pin
`timescale 1ns/100ps
module pwct_pulse_src (
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic [15:0] low_cyc,
	input  wire logic [15:0] high_cyc,
	input  wire logic [3:0]  n_pulse,
	output logic             pin,
	output logic             busy
);
	// ==========================================================
	// pulse train: low phase then high phase, back to back
	initial begin
		pin  = 1'b0;
		busy = 1'b0;
	end
	always @(posedge clk) begin
		if (start) begin
			busy <= 1'b1;
			repeat (n_pulse) begin
				repeat (low_cyc) @(posedge clk);
				pin <= 1'b1; // rising edge for capture 0
				repeat (high_cyc) @(posedge clk);
				pin <= 1'b0; // falling edge for capture 1
			end
			busy <= 1'b0;
		end
	end
endmodule

// ==== test_pulse_width_capture_timer.sv ====
// self-checking testbench of the pulse width capture timer
`timescale 1ns/100ps
module test_pulse_width_capture_timer
	import pwct_pkg::*;
;
	logic              ref_clk, reset_n, ce, avs_read, avs_write;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, q, a, b;
	logic              avs_waitrequest, pin, ff_out, irq0, irq1, irq, src_busy, src_start;
	logic [15:0]       lo_c, hi_c, c0, c1;
	logic [3:0]        np;
	int                bad_count, check_count, n0, n1;
	// ==========================================================
	// clock, dut and partner
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;
	pwct_top u_dut (
		.REF_CLK(ref_clk), .RESET_N(reset_n), .CE(ce), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .CAPTURE_INPUT_PIN(pin),
		.TIMER_FLIPFLOP_OUT(ff_out), .CAPTURE0_IRQ(irq0), .CAPTURE1_IRQ(irq1), .IRQ(irq)
	);
	pwct_pulse_src u_src (
		.clk(ref_clk), .start(src_start), .low_cyc(lo_c), .high_cyc(hi_c),
		.n_pulse(np), .pin(pin), .busy(src_busy)
	);
	always @(posedge ref_clk) begin
		if (irq0 === 1'b1) n0 <= n0 + 1;
		if (irq1 === 1'b1) n1 <= n1 + 1;
	end
	// ==========================================================
	// tasks
	task finish_test;
		begin
			$display("checks %0d errors %0d", check_count, bad_count);
			if (bad_count == 0 && check_count > 0) begin
				$display("*** PASS ***");
			end else begin
				$display("*** FAIL ***");
			end
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		begin
			check_count++;
			if (got !== exp) begin
				bad_count++;
				$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
			end
		end
	endtask
	task bus(input logic rd, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		int n;
		begin
			n = 0;
			avs_address   <= ad;
			avs_writedata <= d;
			avs_read      <= rd;
			avs_write     <= !rd;
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0 && n < 100) begin
				@(posedge ref_clk);
				n++;
			end
			if (n >= 100) chk(1'b0, 1'b1, "bus timeout");
			q = avs_readdata;
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rd_chk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
		begin
			bus(1'b1, ad, RD_ZERO);
			chk(q, e, "read");
		end
	endtask
	task wait_cnt(input int which, input int target);
		int n;
		begin
			n = 0;
			while (((which == 0) ? n0 : n1) < target && n < 500) begin
				@(posedge ref_clk);
				n++;
			end
			chk(((which == 0) ? n0 : n1) >= target, 1'b1, "capture irq wait");
		end
	endtask
	task pulses(input logic [15:0] l, input logic [15:0] h, input logic [3:0] k);
		begin
			lo_c <= l;
			hi_c <= h;
			np <= k;
			src_start <= 1'b1;
			@(posedge ref_clk);
			src_start <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	// ==========================================================
	// tests
	initial begin
		#200000;
		bad_count++;
		finish_test;
	end
	initial begin
		bad_count = 0; check_count = 0; n0 = 0; n1 = 0;
		reset_n = 1'b0; ce = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
		avs_address = '0; avs_writedata = '0; src_start = 1'b0;
		lo_c = 16'h0000; hi_c = 16'h0000; np = 4'h0;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd_chk(OFS_RUN, 32'h0000_0000);
		rd_chk(OFS_FFCTL, 32'h0000_0003);
		rd_chk(OFS_MODE, 32'h0000_0040);
		rd_chk(6'h3C, 32'h0000_0000);
		bus(1'b0, OFS_ENABLE, 32'h0000_0080);
		bus(1'b0, OFS_RUN, 32'h0000_0000);
		bus(1'b0, OFS_FFCTL, 32'h0000_0001);
		chk(ff_out, 1'b1, "ff set");
		bus(1'b0, OFS_FFCTL, 32'h0000_0002);
		chk(ff_out, 1'b0, "ff preset zero");
		bus(1'b0, OFS_MODE, 32'h0000_0061);
		rd_chk(OFS_MODE, 32'h0000_0061);
		bus(1'b0, OFS_MASK, 32'h0000_0002);
		bus(1'b0, OFS_RUN, 32'h0000_0005);
		bus(1'b1, OFS_COUNT, RD_ZERO);
		a = q;
		bus(1'b1, OFS_COUNT, RD_ZERO);
		chk(q !== a, 1'b1, "counter runs");
		// two pulses, high 40 and low 60 cycles, tap1 ticks every 2 cycles
		pulses(16'd60, 16'd40, 4'h2);
		wait_cnt(0, 1);
		chk(irq, 1'b0, "masked cap0");
		wait_cnt(1, 1);
		chk(irq, 1'b1, "cap1 irq");
		bus(1'b1, OFS_CAP0, RD_ZERO);
		c0 = q[15:0];
		bus(1'b1, OFS_CAP1, RD_ZERO);
		c1 = q[15:0];
		chk(16'(c1 - c0), 16'd20, "high width");
		// compare registers reset to zero: first step from zero matches both
		rd_chk(OFS_STATUS, 32'h0000_000F);
		rd_chk(OFS_STATUS, 32'h0000_0000);
		chk(irq, 1'b0, "irq cleared");
		wait_cnt(0, 2);
		bus(1'b1, OFS_CAP0, RD_ZERO);
		chk(16'(q[15:0] - c1), 16'd30, "low width");
		wait_cnt(1, 2);
		while (src_busy === 1'b1) @(posedge ref_clk);
		bus(1'b0, OFS_RUN, 32'h0000_0000);
		bus(1'b1, OFS_COUNT, RD_ZERO);
		a = q;
		bus(1'b1, OFS_COUNT, RD_ZERO);
		chk(q, a, "counter stopped");
		bus(1'b1, OFS_CAP0, RD_ZERO);
		b = q;
		rd_chk(OFS_STATUS, 32'h0000_0003);
		// capture mode off: no capture, registers hold
		bus(1'b0, OFS_MODE, 32'h0000_0041);
		bus(1'b0, OFS_RUN, 32'h0000_0005);
		pulses(16'd6, 16'd12, 4'h1);
		while (src_busy === 1'b1) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		rd_chk(OFS_CAP0, b);
		chk(n0, 2, "no capture irq");
		rd_chk(OFS_STATUS, 32'h0000_0000);
		finish_test;
	end
endmodule
